//--- test/mpu_bus_model.sv
// Host processor model driving the palette bus pins.
// Assumes the bench calls access() and the clock runs freely.
`timescale 1ns/1ps
module mpu_bus_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Bus pins
  output logic            chip_enable_n_o,
  output logic            read_not_write_o,
  output logic            command_sel_lo_o,
  output logic            command_sel_hi_o,
  output logic [7:0]      data_o
);
  initial begin
    chip_enable_n_o = 1'b1;
    read_not_write_o = 1'b1;
    command_sel_lo_o = 1'b0;
    command_sel_hi_o = 1'b0;
    data_o = 8'h5A;
  end

  task automatic access(input logic rnw, input logic [1:0] sel, input logic [7:0] wdata);
    @(negedge sys_clk_i);
    read_not_write_o <= rnw;
    {command_sel_hi_o, command_sel_lo_o} <= sel;
    if (!rnw) data_o <= wdata;
    chip_enable_n_o <= 1'b0;
    repeat (10) @(negedge sys_clk_i);
    chip_enable_n_o <= 1'b1;
    repeat (10) @(negedge sys_clk_i);
    // Released bus must not keep showing the old byte
    data_o <= ~data_o;
  endtask
endmodule

//--- test/palette_port_properties.sv
// Pin-level checker for the palette host access port.
// Assumes it is bound to palette_host_access_port.
`timescale 1ns/1ps
module palette_port_checker
  import palette_pkg::*;
#(
  parameter int IDX_W = INDEX_W
) (
  // Clock and reset
  input wire logic               sys_clk_i,
  input wire logic               srst_i,
  // Host pins
  input wire logic               chip_enable_n_i,
  input wire logic               read_not_write_i,
  input wire logic               command_sel_lo_i,
  input wire logic               command_sel_hi_i,
  input wire logic [DATA_W-1:0]  host_data_bus_i,
  input wire logic [DATA_W-1:0]  host_data_bus_o,
  input wire logic               host_data_bus_oe_o,
  // Display pins
  input wire logic               pixel_load_strobe_i,
  input wire logic               composite_timing_pulse_n_i,
  input wire logic               blank_n_i,
  input wire logic [IDX_W-1:0]   pixel_index_i,
  input wire logic [ENTRY_W-1:0] pixel_color_o,
  input wire logic               pixel_blank_n_o,
  input wire logic               green_sync_on_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_read_drives: assert property ($fell(chip_enable_n_i) && read_not_write_i |-> ##[2:8] host_data_bus_oe_o)
    else $error("read access never drove the bus");
  a_write_quiet: assert property ($fell(chip_enable_n_i) && !read_not_write_i |-> !host_data_bus_oe_o [*8])
    else $error("bus driven during a write");
  a_bus_release: assert property ($rose(chip_enable_n_i) |-> ##[2:8] !host_data_bus_oe_o)
    else $error("bus not released after access");
  a_drive_cause: assert property ($rose(host_data_bus_oe_o) |-> !chip_enable_n_i && read_not_write_i)
    else $error("bus enabled without a read access");
  a_read_stable: assert property (host_data_bus_oe_o && $past(host_data_bus_oe_o) |-> $stable(host_data_bus_o))
    else $error("read byte changed while driven");
  a_sync_off: assert property (
    $rose(pixel_load_strobe_i) && !composite_timing_pulse_n_i |-> ##[2:10] !green_sync_on_o)
    else $error("sync current not removed");
  a_sync_on: assert property (
    $rose(pixel_load_strobe_i) && composite_timing_pulse_n_i |-> ##[2:10] green_sync_on_o)
    else $error("sync current removed without sync");
  a_blank_pass: assert property ($rose(pixel_load_strobe_i) && !blank_n_i |-> ##[2:10] !pixel_blank_n_o)
    else $error("blank level not passed");
  a_reset_quiet: assert property (disable iff (1'b0) srst_i |=> !host_data_bus_oe_o && green_sync_on_o)
    else $error("outputs not idle in reset");

  c_read: cover property ($rose(host_data_bus_oe_o));
  c_sync: cover property ($fell(green_sync_on_o));
  c_write: cover property ($rose(chip_enable_n_i) && !read_not_write_i);
endmodule

bind palette_host_access_port palette_port_checker #(.IDX_W(IDX_W)) u_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .chip_enable_n_i(chip_enable_n_i),
  .read_not_write_i(read_not_write_i), .command_sel_lo_i(command_sel_lo_i),
  .command_sel_hi_i(command_sel_hi_i), .host_data_bus_i(host_data_bus_i),
  .host_data_bus_o(host_data_bus_o), .host_data_bus_oe_o(host_data_bus_oe_o),
  .pixel_load_strobe_i(pixel_load_strobe_i), .composite_timing_pulse_n_i(composite_timing_pulse_n_i),
  .blank_n_i(blank_n_i), .pixel_index_i(pixel_index_i), .pixel_color_o(pixel_color_o),
  .pixel_blank_n_o(pixel_blank_n_o), .green_sync_on_o(green_sync_on_o));

//--- test/tb_top.sv
// Self-checking bench for the palette host access port.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module tb_top;
  import palette_pkg::*;
  logic               sys_clk;
  logic               srst;
  logic               ce_n;
  logic               rnw;
  logic               sel_lo;
  logic               sel_hi;
  logic [7:0]         mpu_d;
  logic [7:0]         bus;
  logic [7:0]         rd_data;
  logic               oe;
  logic               oe_q;
  logic               strobe;
  logic               sync_n;
  logic               blank_n;
  logic [7:0]         pix_idx;
  logic [23:0]        color;
  logic               blank_out_n;
  logic               sync_on;
  logic [7:0]         rgb [6];
  logic [23:0]        exp_q [$];
  int                 bad_count;
  int                 total_checks;
  int                 cycles;

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  assign bus = oe ? rd_data : mpu_d;

  mpu_bus_model mpu (.sys_clk_i(sys_clk), .chip_enable_n_o(ce_n), .read_not_write_o(rnw),
    .command_sel_lo_o(sel_lo), .command_sel_hi_o(sel_hi), .data_o(mpu_d));
  palette_host_access_port dut (.sys_clk_i(sys_clk), .srst_i(srst), .chip_enable_n_i(ce_n),
    .read_not_write_i(rnw), .command_sel_lo_i(sel_lo), .command_sel_hi_i(sel_hi),
    .host_data_bus_i(bus), .host_data_bus_o(rd_data), .host_data_bus_oe_o(oe),
    .pixel_load_strobe_i(strobe), .composite_timing_pulse_n_i(sync_n), .blank_n_i(blank_n),
    .pixel_index_i(pix_idx), .pixel_color_o(color), .pixel_blank_n_o(blank_out_n),
    .green_sync_on_o(sync_on));

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    mpu.access(1'b0, sel, d);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [7:0] e);
    exp_q.push_back({16'h0000, e});
    mpu.access(1'b1, sel, 8'h00);
  endtask
  task automatic pix(input logic [7:0] idx, input logic s_n, input logic b_n, input logic [23:0] e);
    @(negedge sys_clk);
    pix_idx = idx;
    sync_n = s_n;
    blank_n = b_n;
    strobe = 1'b0;
    repeat (3) @(negedge sys_clk);
    strobe = 1'b1;
    repeat (12) @(negedge sys_clk);
    check("pixel colour", color, e);
    check("sync on", {23'h0, sync_on}, {23'h0, s_n});
    check("blank out", {23'h0, blank_out_n}, {23'h0, b_n});
  endtask

  // Compare each read byte as the bus turns on, away from the launching edge
  always @(negedge sys_clk) begin
    oe_q <= oe;
    if (oe && !oe_q) begin
      if (exp_q.size() == 0) check("spare read", 24'h1, 24'h0);
      else check("read byte", {16'h0000, rd_data}, exp_q.pop_front());
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    {srst, strobe, sync_n, blank_n} = 4'hF;
    pix_idx = 8'h00;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(32'h3332));
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    wr(CMD_INDEX, 8'hFE);
    foreach (rgb[i]) begin
      rgb[i] = 8'($urandom);
      wr(CMD_PALETTE, rgb[i]);
    end
    rd(CMD_INDEX, 8'h00);
    wr(CMD_INDEX, 8'hFE);
    foreach (rgb[i]) rd(CMD_PALETTE, rgb[i]);
    rd(CMD_INDEX, 8'h00);
    $display("test stream done");
    wr(CMD_INDEX, 8'h10);
    wr(CMD_PALETTE, 8'hAA);
    wr(CMD_INDEX, 8'h10);
    wr(2'h3, 8'h55);
    for (int i = 1; i < 4; i++) wr(CMD_PALETTE, 8'(i * 17));
    wr(CMD_INDEX, 8'h10);
    for (int i = 1; i < 4; i++) rd(CMD_PALETTE, 8'(i * 17));
    rd(CMD_INDEX, 8'h11);
    $display("test restart done");
    pix(8'hFE, 1'b0, 1'b0, {rgb[0], rgb[1], rgb[2]});
    pix(8'hFF, 1'b1, 1'b0, {rgb[3], rgb[4], rgb[5]});
    pix(8'h10, 1'b1, 1'b1, 24'h112233);
    $display("test pixel done");
    check("reads left", 24'(exp_q.size()), 24'h0);
    stop_test();
  end
endmodule

//--- verilog/palette_dpram.sv
// Dual-port palette memory, one write/read port and one read-only port.
// Assumes single clock; read data registered on each port.
`timescale 1ns/1ps
module palette_dpram #(
  parameter int AW = 8,
  parameter int DW = 24
) (
  // Clock
  input  wire logic          sys_clk_i,
  // Host port
  input  wire logic          a_we_i,
  input  wire logic [AW-1:0] a_addr_i,
  input  wire logic [DW-1:0] a_wdata_i,
  output logic      [DW-1:0] a_rdata_o,
  // Display port
  input  wire logic [AW-1:0] b_addr_i,
  output logic      [DW-1:0] b_rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge sys_clk_i) begin
    if (a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
    a_rdata_o <= mem[a_addr_i];
  end

  always_ff @(posedge sys_clk_i) begin
    b_rdata_o <= mem[b_addr_i];
  end
endmodule

//--- verilog/palette_host_access_port.sv
// Host access port of a 256-entry colour palette with display lookup.
// Assumes host pins and pixel strobe are asynchronous; one 50 MHz clock.
//
// Contract
// - Direction captured at chip enable falling edge
// - Write byte captured at chip enable rise
// - Low is write, high is read driving bus
// - Sync latched per pixel strobe; low removes offset
// - Sync affects only the sync current
// - Two independent memory ports, no display stall
// - One port host, other port display only
// - Eight-bit index register selects host entry
// - Phase counts modulo three, cleared on index
// - Red, green, blue cycles advance the phase
// - Blue write commits joined 24-bit word once
// - Index increments after each blue cycle
// - Index wraps from top entry to zero
// - Palette data uses select low high, high low
// - Index access uses both selects low
// - Selects captured with direction at falling edge
// - Blue read returns blue, then advances both
`timescale 1ns/1ps
module palette_host_access_port
  import palette_pkg::*;
#(
  parameter int IDX_W = INDEX_W
) (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               srst_i,
  // Host bus pins
  input  wire logic               chip_enable_n_i,
  input  wire logic               read_not_write_i,
  input  wire logic               command_sel_lo_i,
  input  wire logic               command_sel_hi_i,
  input  wire logic [DATA_W-1:0]  host_data_bus_i,
  output logic      [DATA_W-1:0]  host_data_bus_o,
  output logic                    host_data_bus_oe_o,
  // Display side
  input  wire logic               pixel_load_strobe_i,
  input  wire logic               composite_timing_pulse_n_i,
  input  wire logic               blank_n_i,
  input  wire logic [IDX_W-1:0]   pixel_index_i,
  output logic      [ENTRY_W-1:0] pixel_color_o,
  output logic                    pixel_blank_n_o,
  output logic                    green_sync_on_o
);
  typedef enum logic [1:0] {IDLE, ACTIVE} access_t;

  access_t            state;
  logic [1:0]         color_phase_count;
  logic [IDX_W-1:0]   palette_index_reg;
  logic [DATA_W-1:0]  red_hold;
  logic [DATA_W-1:0]  green_hold;
  logic               dir_read;
  logic [1:0]         cmd;
  logic [DATA_W-1:0]  rd_byte;
  logic               ld_prev;
  logic [IDX_W-1:0]   disp_index;
  logic               disp_sync_n;
  logic               disp_blank_n;
  logic               lookup_valid;
  logic               lookup_done;
  logic               sync_pipe;
  logic               blank_pipe;

  // Synchronised pins
  logic [3:0]         ctl_sync;
  logic [DATA_W-1:0]  data_sync;
  logic [IDX_W+2:0]   pix_sync;

  pin_sync #(.WIDTH(4)) u_ctl_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .pin_i     ({chip_enable_n_i, read_not_write_i, command_sel_hi_i, command_sel_lo_i}),
    .level_o   (ctl_sync)
  );

  pin_sync #(.WIDTH(DATA_W)) u_data_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .pin_i     (host_data_bus_i),
    .level_o   (data_sync)
  );

  pin_sync #(.WIDTH(IDX_W+3)) u_pix_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .pin_i     ({pixel_load_strobe_i, composite_timing_pulse_n_i, blank_n_i, pixel_index_i}),
    .level_o   (pix_sync)
  );

  wire              ce_n       = ctl_sync[3];
  wire              ce_fall    = (state == IDLE) && !ce_n;
  wire              ce_rise    = (state == ACTIVE) && ce_n;
  wire              is_index   = (cmd == CMD_INDEX);
  wire              is_palette = (cmd == CMD_PALETTE);
  wire              is_blue    = (color_phase_count == PHASE_BLUE);
  wire              end_index  = ce_rise && is_index;
  wire              end_pal    = ce_rise && is_palette;
  wire              wr_entry   = end_pal && !dir_read && is_blue;
  wire [ENTRY_W-1:0] new_entry = {red_hold, green_hold, data_sync};
  wire [ENTRY_W-1:0] host_rdata;
  wire [ENTRY_W-1:0] disp_rdata;
  wire [1:0]        next_phase = is_blue ? PHASE_RED : color_phase_count + 2'h1;
  wire [IDX_W-1:0]  next_index = palette_index_reg + {{(IDX_W-1){1'b0}}, 1'b1};
  wire              ld_rise    = pix_sync[IDX_W+2] && !ld_prev;

  // Access capture
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state    <= IDLE;
      dir_read <= 1'b0;
      cmd      <= CMD_INDEX;
    end else if (ce_fall) begin
      state    <= ACTIVE;
      dir_read <= ctl_sync[2];
      cmd      <= ctl_sync[1:0];
    end else if (ce_rise) begin
      state    <= IDLE;
    end
  end

  // Index register and colour phase
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      palette_index_reg <= INDEX_RESET[IDX_W-1:0];
      color_phase_count <= PHASE_RED;
    end else if (end_index) begin
      color_phase_count <= PHASE_RED;
      if (!dir_read) begin
        palette_index_reg <= data_sync[IDX_W-1:0];
      end
    end else if (end_pal) begin
      color_phase_count <= next_phase;
      if (is_blue) begin
        palette_index_reg <= next_index;
      end
    end
  end

  // Red and green holding bytes
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      red_hold   <= 8'h00;
      green_hold <= 8'h00;
    end else if (end_pal && !dir_read) begin
      if (color_phase_count == PHASE_RED) begin
        red_hold <= data_sync;
      end
      if (color_phase_count == PHASE_GREEN) begin
        green_hold <= data_sync;
      end
    end
  end

  // Read byte select
  always_comb begin
    rd_byte = 8'h00;
    if (is_index) begin
      rd_byte = palette_index_reg[DATA_W-1:0];
    end else if (is_palette) begin
      unique case (color_phase_count)
        PHASE_RED:   rd_byte = host_rdata[23:16];
        PHASE_GREEN: rd_byte = host_rdata[15:8];
        default:     rd_byte = host_rdata[7:0];
      endcase
    end
  end

  // Bus drive
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      host_data_bus_o    <= 8'h00;
      host_data_bus_oe_o <= 1'b0;
    end else begin
      host_data_bus_o    <= rd_byte;
      host_data_bus_oe_o <= (state == ACTIVE) && dir_read && !ce_n;
    end
  end

  palette_dpram #(.AW(IDX_W), .DW(ENTRY_W)) u_ram (
    .sys_clk_i (sys_clk_i),
    .a_we_i    (wr_entry),
    .a_addr_i  (palette_index_reg),
    .a_wdata_i (new_entry),
    .a_rdata_o (host_rdata),
    .b_addr_i  (disp_index),
    .b_rdata_o (disp_rdata)
  );

  // Pixel latch on strobe rise
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      // Matches the filtered strobe's reset level, so no false edge
      ld_prev      <= 1'b1;
      disp_index   <= INDEX_RESET[IDX_W-1:0];
      disp_sync_n  <= 1'b1;
      disp_blank_n <= 1'b1;
      lookup_valid <= 1'b0;
    end else begin
      ld_prev      <= pix_sync[IDX_W+2];
      lookup_valid <= ld_rise;
      if (ld_rise) begin
        disp_index   <= pix_sync[IDX_W-1:0];
        disp_sync_n  <= pix_sync[IDX_W+1];
        disp_blank_n <= pix_sync[IDX_W];
      end
    end
  end

  // Display outputs, aligned to the registered lookup
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sync_pipe       <= 1'b1;
      blank_pipe      <= 1'b1;
      lookup_done     <= 1'b0;
      pixel_color_o   <= ENTRY_RESET;
      pixel_blank_n_o <= 1'b1;
      green_sync_on_o <= 1'b1;
    end else begin
      sync_pipe  <= disp_sync_n;
      blank_pipe <= disp_blank_n;
      // Display read data lags the latched index by one cycle
      lookup_done <= lookup_valid;
      if (lookup_done) begin
        pixel_color_o   <= disp_rdata;
      end
      pixel_blank_n_o <= blank_pipe;
      green_sync_on_o <= sync_pipe;
    end
  end
endmodule

//--- verilog/palette_pkg.sv
// Shared constants for the palette host access port.
// Assumes a single 50 MHz system clock domain.
package palette_pkg;
  localparam int          CLK_MHZ          = 50;
  localparam int          DATA_W           = 8;
  localparam int          INDEX_W          = 8;
  localparam int          ENTRY_W          = 24;
  localparam int          ENTRIES          = 256;
  localparam logic [1:0]  CMD_INDEX        = 2'h0;
  localparam logic [1:0]  CMD_PALETTE      = 2'h1;
  localparam logic [1:0]  PHASE_RED        = 2'h0;
  localparam logic [1:0]  PHASE_GREEN      = 2'h1;
  localparam logic [1:0]  PHASE_BLUE       = 2'h2;
  localparam logic [7:0]  INDEX_RESET      = 8'h00;
  localparam logic [23:0] ENTRY_RESET      = 24'h000000;
  localparam int          SYNC_STAGES      = 3;
endpackage

//--- verilog/pin_sync.sv
// Three-flop pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to sys_clk_i.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  // Pins
  input  wire logic [WIDTH-1:0] pin_i,
  // Filtered level
  output logic      [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // Change accepted once second and third stages agree
  always_ff @(posedge sys_clk_i) begin
    s1 <= pin_i;
    s2 <= s1;
    s3 <= s2;
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          level_o[i] <= 1'b1;
        end else if (s2[i] == s3[i]) begin
          level_o[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule
